/* File: design/serial2_sync_port.sv */
// Serial channel two: control register 0, bus slave, FIFO and synchronous shifter.
`timescale 1ns/10ps
module serial2_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_ff;
   logic [AW-1:0] rdPtr_ff;
   logic [AW:0] count_ff;
   logic doWr;
   logic doRd;

   // Handshake terms; full and empty come straight from the count.
   assign inReady = (count_ff != (AW+1)'(DEPTH));
   assign outValid = (count_ff != '0);
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;
   assign outData = mem[rdPtr_ff];

   // Storage array is written at the write pointer.
   always_ff @(posedge core_clk) begin
      if (doWr) begin
         mem[wrPtr_ff] <= inData;
      end
   end

   // Pointers and occupancy.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (doWr) begin
            wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
         end
         if (doRd) begin
            rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
         end
         count_ff <= count_ff + (AW+1)'(doWr) - (AW+1)'(doRd);
      end
   end
endmodule

module serial2_sync_port #(
   parameter int WIDTH = serial2_pkg::DATA_BITS,
   parameter int DEPTH = serial2_pkg::FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic xferClkIn,
   output logic xferClkOut,
   output logic xferClkOe,
   output logic txData,
   input wire logic rxData
);
   typedef enum logic [1:0] {IDLE, LOAD, SHIFT, DONE} shift_state_t;

   logic [7:0] ctrl_ff;
   logic [7:0] div_ff;
   logic extClk_ff;
   logic [11:0] awAddr_ff;
   logic awHeld_ff;
   logic [31:0] wData_ff;
   logic wHeld_ff;
   logic [11:0] arAddr_ff;
   logic [31:0] rData_ff;
   logic [1:0] rResp_ff;
   logic bValid_ff;
   logic [1:0] bResp_ff;
   logic rValid_ff;
   logic [WIDTH-1:0] rxWord_ff;
   logic rxFull_ff;
   logic [1:0] clkSync_ff;
   logic clkPrev_ff;
   logic [1:0] rxSync_ff;
   logic [4:0] pre_ff;
   logic [7:0] brg_ff;
   logic intClk_ff;
   shift_state_t state_ff;
   logic [WIDTH-1:0] shReg_ff;
   logic [WIDTH-1:0] rxShift_ff;
   logic [3:0] bitCnt_ff;
   logic txData_ff;
   logic fifoInValid;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [WIDTH-1:0] fifoOutData;
   logic doWrite;
   logic preTick;
   logic brgTick;
   logic linkClk;
   logic riseEdge;
   logic fallEdge;
   logic driveEdge;
   logic sampleEdge;
   logic txEmpty;
   logic [4:0] preMax;
   logic wLane0_ff;
   logic [7:0] ctrl0Read;

   // --------------------------------------------------------------------------
   // Bit-rate generator
   // --------------------------------------------------------------------------

   // Prescaler terminal count follows the clock-source field.
   always_comb begin
      case (ctrl_ff[serial2_pkg::SRC_MSB:serial2_pkg::SRC_LSB])
         serial2_pkg::SRC_F1: preMax = '0;
         serial2_pkg::SRC_F8: preMax = serial2_pkg::PRE_F8;
         serial2_pkg::SRC_F32: preMax = serial2_pkg::PRE_F32;
         default: preMax = serial2_pkg::PRE_F32; // Forbidden code, held at slowest.
      endcase
   end
   assign preTick = (pre_ff >= preMax);
   assign brgTick = preTick && (brg_ff == '0);

   // The fastest source lets the prescaler pass every core clock.
   src_fast_a: assert property (@(posedge core_clk) disable iff (rst)
      (ctrl_ff[serial2_pkg::SRC_MSB:serial2_pkg::SRC_LSB] == serial2_pkg::SRC_F1) |-> preTick)
      else $error("Prescaler stalled with the fastest source.");

   // Prescaler, divider and internal transfer clock (fi / 2(n+1)).
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pre_ff <= '0;
         brg_ff <= '0;
         intClk_ff <= 1'b1;
      end else begin
         pre_ff <= preTick ? '0 : pre_ff + 1'b1;
         if (preTick) begin
            brg_ff <= (brg_ff == '0) ? div_ff : brg_ff - 1'b1;
         end
         // The clock parks at its idle level outside a frame and stops after the last bit.
         if (state_ff != SHIFT) begin
            intClk_ff <= ~ctrl_ff[serial2_pkg::POL_BIT];
         end else if (brgTick && bitCnt_ff != 4'(WIDTH)) begin
            intClk_ff <= ~intClk_ff;
         end
      end
   end

   // A frame always opens on the drive edge, so the clock must rest at its idle level.
   clk_idle_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff != SHIFT) |=> (xferClkOut != $past(ctrl_ff[serial2_pkg::POL_BIT])))
      else $error("Internal transfer clock not parked at its idle level.");

   // --------------------------------------------------------------------------
   // Link side: synchronisers and edge finding
   // --------------------------------------------------------------------------

   // Two-stage synchronisers for the external clock and receive data.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clkSync_ff <= 2'h3;
         rxSync_ff <= 2'h3;
         clkPrev_ff <= 1'b1;
      end else begin
         clkSync_ff <= {clkSync_ff[0], xferClkIn};
         rxSync_ff <= {rxSync_ff[0], rxData};
         clkPrev_ff <= linkClk;
      end
   end
   assign linkClk = extClk_ff ? clkSync_ff[1] : intClk_ff;
   assign riseEdge = linkClk && !clkPrev_ff;
   assign fallEdge = !linkClk && clkPrev_ff;
   assign driveEdge = ctrl_ff[serial2_pkg::POL_BIT] ? riseEdge : fallEdge;
   assign sampleEdge = ctrl_ff[serial2_pkg::POL_BIT] ? fallEdge : riseEdge;
   assign xferClkOut = intClk_ff;
   assign xferClkOe = !extClk_ff;
   assign txData = txData_ff;
   assign txEmpty = (state_ff == IDLE);
   assign fifoOutReady = (state_ff == IDLE);

   // --------------------------------------------------------------------------
   // Shifter
   // --------------------------------------------------------------------------

   // Transmit/receive sequencer: one drive and one sample edge per bit.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= IDLE;
         shReg_ff <= '0;
         rxShift_ff <= '0;
         bitCnt_ff <= '0;
         txData_ff <= 1'b1;
      end else begin
         case (state_ff)
            IDLE: begin
               if (fifoOutValid) begin
                  shReg_ff <= fifoOutData;
                  bitCnt_ff <= '0;
                  state_ff <= LOAD;
               end
            end
            LOAD: begin
               // One cycle lets the internal clock settle at its idle level.
               state_ff <= SHIFT;
            end
            SHIFT: begin
               if (driveEdge && bitCnt_ff != 4'(WIDTH)) begin
                  txData_ff <= ctrl_ff[serial2_pkg::ORDER_BIT] ? shReg_ff[WIDTH-1] : shReg_ff[0];
                  shReg_ff <= ctrl_ff[serial2_pkg::ORDER_BIT] ?
                     {shReg_ff[WIDTH-2:0], 1'b0} : {1'b0, shReg_ff[WIDTH-1:1]};
               end
               if (sampleEdge && bitCnt_ff != 4'(WIDTH)) begin
                  rxShift_ff <= ctrl_ff[serial2_pkg::ORDER_BIT] ?
                     {rxShift_ff[WIDTH-2:0], rxSync_ff[1]} : {rxSync_ff[1], rxShift_ff[WIDTH-1:1]};
                  bitCnt_ff <= bitCnt_ff + 1'b1;
               end
               if (bitCnt_ff == 4'(WIDTH)) begin
                  state_ff <= DONE;
               end
            end
            DONE: begin
               txData_ff <= 1'b1;
               state_ff <= IDLE;
            end
            default: state_ff <= IDLE;
         endcase
      end
   end

   // Empty flag reads 0 while a word occupies the shift register.
   empty_flag_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff == SHIFT) |-> !ctrl0Read[serial2_pkg::EMPTY_BIT])
      else $error("Empty flag high during shifting.");
   order_first_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff == SHIFT && driveEdge && bitCnt_ff == '0 && !ctrl_ff[serial2_pkg::ORDER_BIT])
      |=> txData_ff == $past(shReg_ff[0]))
      else $error("First bit not LSB.");
   drive_edge_a: assert property (@(posedge core_clk) disable iff (rst)
      $changed(txData_ff) && state_ff == SHIFT |-> $past(driveEdge))
      else $error("Transmit data changed off the drive edge.");
   order_msb_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff == SHIFT && driveEdge && bitCnt_ff == '0 && ctrl_ff[serial2_pkg::ORDER_BIT])
      |=> txData_ff == $past(shReg_ff[WIDTH-1]))
      else $error("First bit not MSB.");

   // --------------------------------------------------------------------------
   // AXI4-Lite slave
   // --------------------------------------------------------------------------
   assign ctrl0Read = {ctrl_ff[serial2_pkg::ORDER_BIT], ctrl_ff[serial2_pkg::POL_BIT],
      1'b0, ctrl_ff[serial2_pkg::RES1_BIT], txEmpty, ctrl_ff[serial2_pkg::RES0_BIT],
      ctrl_ff[serial2_pkg::SRC_MSB:serial2_pkg::SRC_LSB]};
   assign s_axi_awready = !awHeld_ff;
   assign s_axi_wready = !wHeld_ff;
   assign s_axi_bvalid = bValid_ff;
   assign s_axi_bresp = bResp_ff;
   assign s_axi_arready = !rValid_ff;
   assign s_axi_rvalid = rValid_ff;
   assign s_axi_rdata = rData_ff;
   assign s_axi_rresp = rResp_ff;
   assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
   assign fifoInValid = doWrite && awAddr_ff == serial2_pkg::DATA_ADDR && wLane0_ff;

   // Write address and data are captured independently, then answered together.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         awHeld_ff <= 1'b0;
         wHeld_ff <= 1'b0;
         awAddr_ff <= '0;
         wData_ff <= '0;
         wLane0_ff <= 1'b0;
         bValid_ff <= 1'b0;
         bResp_ff <= serial2_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !awHeld_ff) begin
            awAddr_ff <= s_axi_awaddr;
            awHeld_ff <= 1'b1;
         end
         if (s_axi_wvalid && !wHeld_ff) begin
            wData_ff <= s_axi_wdata;
            wLane0_ff <= s_axi_wstrb[0]; // The strobe travels with its data word.
            wHeld_ff <= 1'b1;
         end
         if (doWrite && (awAddr_ff != serial2_pkg::DATA_ADDR || fifoInReady)) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            bValid_ff <= 1'b1;
            bResp_ff <= (awAddr_ff == serial2_pkg::CTRL0_ADDR || awAddr_ff ==
               serial2_pkg::DATA_ADDR || awAddr_ff == serial2_pkg::DIV_ADDR ||
               awAddr_ff == serial2_pkg::MODE_ADDR || awAddr_ff == serial2_pkg::STAT_ADDR)
               ? serial2_pkg::RESP_OKAY : serial2_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bValid_ff <= 1'b0;
         end
      end
   end

   // Writable registers; the empty flag and unassigned bit ignore writes.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= serial2_pkg::CTRL0_RESET;
         div_ff <= serial2_pkg::DIV_RESET;
         extClk_ff <= 1'b0;
      end else if (doWrite && wLane0_ff) begin
         if (awAddr_ff == serial2_pkg::CTRL0_ADDR) begin
            // Flag and unassigned positions stay clear; the read path rebuilds them.
            ctrl_ff <= wData_ff[7:0] & ~((8'h01 << serial2_pkg::EMPTY_BIT) |
               (8'h01 << serial2_pkg::UNASG_BIT));
         end
         if (awAddr_ff == serial2_pkg::DIV_ADDR) begin
            div_ff <= wData_ff[7:0];
         end
         if (awAddr_ff == serial2_pkg::MODE_ADDR && state_ff == IDLE) begin
            extClk_ff <= wData_ff[0];
         end
      end
   end

   // Receive holding word, valid until status read by data read.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxWord_ff <= '0;
         rxFull_ff <= 1'b0;
      end else if (state_ff == DONE) begin
         rxWord_ff <= rxShift_ff;
         rxFull_ff <= 1'b1; // Set wins over a same-cycle read.
      end else if (s_axi_arvalid && !rValid_ff && s_axi_araddr == serial2_pkg::DATA_ADDR) begin
         rxFull_ff <= 1'b0;
      end
   end

   // Read channel: one cycle from address to data.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rValid_ff <= 1'b0;
         rData_ff <= '0;
         rResp_ff <= serial2_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !rValid_ff) begin
         rValid_ff <= 1'b1;
         rResp_ff <= serial2_pkg::RESP_OKAY;
         case (s_axi_araddr)
            serial2_pkg::CTRL0_ADDR: rData_ff <= {24'h000000, ctrl0Read};
            serial2_pkg::DATA_ADDR: rData_ff <= {24'h000000, rxWord_ff};
            serial2_pkg::STAT_ADDR: rData_ff <= {29'h00000000, rxFull_ff, fifoInReady, txEmpty};
            serial2_pkg::DIV_ADDR: rData_ff <= {24'h000000, div_ff};
            serial2_pkg::MODE_ADDR: rData_ff <= {31'h00000000, extClk_ff};
            default: begin
               rData_ff <= '0;
               rResp_ff <= serial2_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rValid_ff <= 1'b0;
      end
   end

   unassigned_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      rValid_ff && $past(s_axi_araddr) == serial2_pkg::CTRL0_ADDR && $rose(rValid_ff)
      |-> !rData_ff[serial2_pkg::UNASG_BIT])
      else $error("Unassigned bit read as one.");

   serial2_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH)
   ) txFifo (
      .core_clk(core_clk),
      .rst(rst),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(wData_ff[WIDTH-1:0]),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );
endmodule

/* File: common/serial2_pkg.sv */
// Package of register offsets, field positions, reset values and timing constants.
package serial2_pkg;
   // --------------------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------------------
   localparam logic [11:0] CTRL0_ADDR = 12'h37C;
   localparam logic [11:0] DATA_ADDR = 12'h380;
   localparam logic [11:0] STAT_ADDR = 12'h384;
   localparam logic [11:0] DIV_ADDR = 12'h388;
   localparam logic [11:0] MODE_ADDR = 12'h38C;
   // --------------------------------------------------------------------------
   // Control register 0 fields
   // --------------------------------------------------------------------------
   localparam int SRC_LSB = 0;
   localparam int SRC_MSB = 1;
   localparam int RES0_BIT = 2;
   localparam int EMPTY_BIT = 3;
   localparam int RES1_BIT = 4;
   localparam int UNASG_BIT = 5;
   localparam int POL_BIT = 6;
   localparam int ORDER_BIT = 7;
   localparam logic [7:0] CTRL0_RESET = 8'h18;
   localparam logic [1:0] SRC_F1 = 2'h0;
   localparam logic [1:0] SRC_F8 = 2'h1;
   localparam logic [1:0] SRC_F32 = 2'h2;
   localparam logic [4:0] PRE_F8 = 5'h07;
   localparam logic [4:0] PRE_F32 = 5'h1F;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int DATA_BITS = 8;
   localparam int FIFO_DEPTH = 8;
endpackage

/* File: sim/serial2_peer.sv */
// Serial peer model that follows the transfer clock line and swaps one byte per frame.
`timescale 1ns/10ps
module serial2_peer (
   input wire logic clkLine,
   input wire logic pol,
   input wire logic txLine,
   output logic clkDrive,
   output logic rxLine,
   output logic [7:0] gotBits
);
   logic [7:0] sendBits;
   logic active;
   int edgeCount;
   // Loads the next byte in wire order and parks the clock at its idle level.
   task automatic arm(input logic [7:0] bits);
      sendBits = bits;
      edgeCount = 0;
      active = 1'h0;
      clkDrive = ~pol;
   endtask
   // Makes eight transfer clock cycles of 125 ns, then the clock stands still.
   task automatic runFrame();
      repeat (8) begin
         #62.5 clkDrive = pol;
         #62.5 clkDrive = ~pol;
      end
   endtask
   // Drives on the leading edge of each cycle and samples on the trailing edge.
   always @(clkLine) begin
      if (clkLine === pol && edgeCount < 8) begin
         active = 1'h1;
         rxLine = sendBits[7 - edgeCount];
      end else if (clkLine === ~pol && active && edgeCount < 8) begin
         gotBits = {gotBits[6:0], txLine};
         edgeCount++;
      end
   end
   // The last bit is held until the next arm; then the line keeps changing until the frame.
   always #7 if (!active) rxLine = ~rxLine;
   // Starts idle with nothing sent.
   initial begin
      clkDrive = 1'h1;
      rxLine = 1'h1;
      gotBits = 8'h00;
      sendBits = 8'h00;
      active = 1'h0;
      edgeCount = 0;
   end
endmodule

/* File: sim/test_serial_port_control_reg0.sv */
// Bench for serial channel two: control register 0, transmit FIFO and link traffic.
`timescale 1ns/10ps
module test_serial_port_control_reg0;
   // ---------------------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------------------
   logic core_clk = 1'h0, rst = 1'h1;
   logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
   logic [31:0] wData = 32'h0, rData;
   logic [3:0] wStrb = 4'hF;
   logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
   logic awReady, wReady, bValid, arReady, rValid, clkOut, clkOe, txLine, rxLine, peerClk;
   logic clkLine, polSel = 1'h0, msbFirst = 1'h0, lastClk = 1'h1;
   logic [1:0] bResp, rResp;
   logic [7:0] gotBits;
   int errTotal = 0, nCompared = 0, sinceEdge = 0, halfSeen = 0;
   // The clock pin carries whichever party has it enabled.
   assign clkLine = clkOe ? clkOut : peerClk;
   always #2.5 core_clk = ~core_clk;
   serial2_sync_port serial2_sync_port_i (.core_clk(core_clk), .rst(rst),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .xferClkIn(clkLine), .xferClkOut(clkOut), .xferClkOe(clkOe), .txData(txLine),
      .rxData(rxLine));
   serial2_peer serial2_peer_i (.clkLine(clkLine), .pol(polSel), .txLine(txLine),
      .clkDrive(peerClk), .rxLine(rxLine), .gotBits(gotBits));
   // Measures the last interval between transfer clock edges in core cycles.
   always @(posedge core_clk) begin
      lastClk <= clkOut;
      if (clkOut !== lastClk) begin
         halfSeen <= sinceEdge + 1;
         sinceEdge <= 0;
      end else begin
         sinceEdge <= sinceEdge + 1;
      end
   end
   // ---------------------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------------------
   task automatic giveVerdict();
      if (errTotal == 0 && nCompared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      nCompared++;
      if (got !== exp) begin
         errTotal++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Wire order of a byte: bit 7 of the result travels first.
   function automatic logic [7:0] wireOf(input logic [7:0] b, input logic msb);
      logic [7:0] w;
      for (int i = 0; i < 8; i++) w[7 - i] = msb ? b[7 - i] : b[i];
      return w;
   endfunction
   // One AXI4-Lite write or read; handshakes are sampled where they are stable.
   task automatic axi(input logic isWr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic [1:0] r);
      logic awHit, wHit, bHit, arHit, rHit;
      int n;
      @(posedge core_clk);
      if (isWr) begin
         awAddr <= a;
         wData <= d;
         awValid <= 1'h1;
         wValid <= 1'h1;
         bReady <= 1'h1;
      end else begin
         arAddr <= a;
         arValid <= 1'h1;
         rReady <= 1'h1;
      end
      for (n = 0; n < 4000; n++) begin
         @(negedge core_clk);
         awHit = awValid && awReady;
         wHit = wValid && wReady;
         bHit = bValid && bReady;
         arHit = arValid && arReady;
         rHit = rValid && rReady;
         q = rData;
         r = isWr ? bResp : rResp;
         @(posedge core_clk);
         if (awHit) awValid <= 1'h0;
         if (wHit) wValid <= 1'h0;
         if (arHit) arValid <= 1'h0;
         if (bHit) bReady <= 1'h0;
         if (rHit) rReady <= 1'h0;
         if (bHit || rHit) break;
      end
      if (n == 4000) begin
         errTotal++;
         giveVerdict();
      end
   endtask
   // Writes control register 0 with random polarity and order, then reads it back.
   task automatic setCtrl(input logic [1:0] src);
      logic [31:0] q;
      logic [31:0] v;
      logic [1:0] r;
      polSel = 1'($urandom);
      msbFirst = 1'($urandom);
      v = {24'h0, msbFirst, polSel, 4'h4, src};
      axi(1'h1, serial2_pkg::CTRL0_ADDR, v, q, r);
      check("ctrl0 bresp", 32'(serial2_pkg::RESP_OKAY), 32'(r));
      axi(1'h0, serial2_pkg::CTRL0_ADDR, 32'h0, q, r);
      check("ctrl0", {24'h0, msbFirst, polSel, 4'h6, src}, q);
   endtask
   // One full duplex byte exchange; the transmit byte may already be queued.
   task automatic frame(input logic [7:0] txB, input logic ext, input logic doWrite);
      logic [31:0] q;
      logic [1:0] r;
      logic [7:0] rxB;
      int n;
      rxB = 8'($urandom);
      serial2_peer_i.arm(wireOf(rxB, msbFirst));
      if (doWrite) axi(1'h1, serial2_pkg::DATA_ADDR, {24'h0, txB}, q, r);
      axi(1'h0, serial2_pkg::CTRL0_ADDR, 32'h0, q, r);
      check("shift empty busy", 32'h0, 32'(q[3]));
      if (ext) serial2_peer_i.runFrame();
      for (n = 0; n < 2000 && q[2] !== 1'h1; n++) axi(1'h0, serial2_pkg::STAT_ADDR, 32'h0, q, r);
      check("rx ready", 32'h1, 32'(q[2]));
      if (q[2] !== 1'h1) giveVerdict();
      axi(1'h0, serial2_pkg::DATA_ADDR, 32'h0, q, r);
      check("rx byte", {24'h0, rxB}, q);
      check("tx wire", {24'h0, wireOf(txB, msbFirst)}, {24'h0, gotBits});
   endtask
   // ---------------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic [1:0] r;
      logic [7:0] txQ[$];
      int k;
      void'($urandom(20));
      repeat (3) @(posedge core_clk);
      rst <= 1'h0;
      axi(1'h0, serial2_pkg::CTRL0_ADDR, 32'h0, q, r);
      check("ctrl0 reset", 32'h18, q);
      axi(1'h0, 12'h3F0, 32'h0, q, r);
      check("unmapped resp", 32'(serial2_pkg::RESP_SLVERR), 32'(r));
      check("unmapped data", 32'h0, q);
      wStrb <= 4'h0;
      axi(1'h1, serial2_pkg::CTRL0_ADDR, 32'h92, q, r);
      check("masked write resp", 32'(serial2_pkg::RESP_OKAY), 32'(r));
      wStrb <= 4'hF;
      axi(1'h0, serial2_pkg::CTRL0_ADDR, 32'h0, q, r);
      check("ctrl0 masked", 32'h18, q);
      axi(1'h1, serial2_pkg::DIV_ADDR, 32'h1, q, r);
      for (k = 0; k < 6; k++) begin
         setCtrl(2'(k % 3));
         frame(k == 0 ? 8'h01 : k == 1 ? 8'h80 : 8'($urandom), 1'h0, 1'h1);
         check("half period", (k % 3 == 0) ? 2 : (k % 3 == 1) ? 16 : 64, halfSeen);
      end
      setCtrl(2'h0);
      serial2_peer_i.arm(8'h00);
      axi(1'h1, serial2_pkg::MODE_ADDR, 32'h1, q, r);
      check("clock drive enable", 32'h0, 32'(clkOe));
      q = 32'h2;
      for (k = 0; k < 12 && q[1] === 1'h1; k++) begin
         txQ.push_back(8'($urandom));
         axi(1'h1, serial2_pkg::DATA_ADDR, {24'h0, txQ[k]}, q, r);
         axi(1'h0, serial2_pkg::STAT_ADDR, 32'h0, q, r);
      end
      check("fifo full", 32'h0, 32'(q[1]));
      check("fifo depth", serial2_pkg::FIFO_DEPTH + 1, k);
      foreach (txQ[i]) frame(txQ[i], 1'h1, 1'h0);
      axi(1'h0, serial2_pkg::CTRL0_ADDR, 32'h0, q, r);
      check("shift empty idle", 32'h1, 32'(q[3]));
      giveVerdict();
   end
endmodule
